// ### include/pdfs_pkg.sv
// Shared constants, types and lookups for the port direction and function select block
`default_nettype none

package pdfs_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 28;
  localparam int DATA_W = 16;
  localparam int PINS   = 16;

  // ==========================================================================
  // Register offsets, as printed
  localparam logic [ADDR_W-1:0] OFS_PA_DIR   = 28'h5ffffc4;
  localparam logic [ADDR_W-1:0] OFS_PB_DIR   = 28'h5ffffc6;
  localparam logic [ADDR_W-1:0] OFS_PA_UPPER = 28'h5ffffc8;
  localparam logic [ADDR_W-1:0] OFS_PA_LOWER = 28'h5ffffca;

  // ==========================================================================
  // Reset values, writable masks and fixed read-as-one bits
  localparam logic [DATA_W-1:0] RST_DIR       = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PA_UPPER  = 16'h3302;
  localparam logic [DATA_W-1:0] RST_PA_LOWER  = 16'hff95;
  localparam logic [DATA_W-1:0] WMASK_UPPER   = 16'hfffd;
  localparam logic [DATA_W-1:0] FIXED_UPPER   = 16'h0002;
  localparam logic [DATA_W-1:0] WMASK_LOWER   = 16'h55ff;
  localparam logic [DATA_W-1:0] FIXED_LOWER   = 16'haa00;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 16'h0000;

  // ==========================================================================
  // Field layout: pins at or above PIN_UPPER_2B use two-bit fields in the
  // upper register at 2*(pin-PIN_SINGLE_HI); PIN_SINGLE_HI is one bit at 0;
  // pins at or above PIN_SINGLE_LO use one bit at 2*pin of the lower
  // register; the rest use two-bit fields at 2*pin.
  localparam int PIN_UPPER_2B  = 9;
  localparam int PIN_SINGLE_HI = 8;
  localparam int PIN_SINGLE_LO = 4;

  // ==========================================================================
  // Function codes of a pin field
  localparam logic [1:0] CODE_GPIO = 2'b00;
  localparam logic [1:0] CODE_F1   = 2'b01;
  localparam logic [1:0] CODE_F2   = 2'b10;
  localparam logic [1:0] CODE_F3   = 2'b11;

  // Drive class of a selected function
  typedef enum logic [2:0] {
    PDFS_KIND_GPIO = 3'h0,
    PDFS_KIND_IN   = 3'h1,
    PDFS_KIND_OUT  = 3'h3,
    PDFS_KIND_IO   = 3'h2,
    PDFS_KIND_RSV  = 3'h6
  } pdfs_kind_t;

  // One enable per peripheral function routed onto port A
  typedef struct packed {
    logic ext_int3_in;
    logic dma_req1_in;
    logic ext_int2_in;
    logic dma_ack1_out;
    logic ext_int1_in;
    logic timer_ext_clk_b;
    logic dma_req1_alt_in;
    logic ext_int0_in;
    logic timer_ext_clk_a;
    logic dma_ack0_out;
    logic hi_parity_io;
    logic timer1_capcmp_b;
    logic lo_parity_io;
    logic timer1_capcmp_a;
    logic address_hold_out;
    logic converter_trigger_in;
    logic int_request_out;
    logic bus_request_in;
    logic bus_grant_out;
    logic read_strobe_out;
    logic high_store_strobe;
    logic low_store_strobe;
    logic chip_sel7_out;
    logic wait_state_in;
    logic chip_sel6_out;
    logic timer0_capcmp_b;
    logic chip_sel5_out;
    logic row_addr_strobe_out;
    logic chip_sel4_out;
    logic timer0_capcmp_a;
  } pdfs_func_en_t;

  function automatic pdfs_kind_t pdfs_pick(input logic [1:0] c,
                                           input pdfs_kind_t k0,
                                           input pdfs_kind_t k1,
                                           input pdfs_kind_t k2,
                                           input pdfs_kind_t k3);
    case (c)
      CODE_GPIO: return k0;
      CODE_F1:   return k1;
      CODE_F2:   return k2;
      default:   return k3;
    endcase
  endfunction : pdfs_pick

  // Drive class of each port A pin for each code
  function automatic pdfs_kind_t pdfs_pin_kind(input logic [3:0] pin,
                                               input logic [1:0] c);
    pdfs_kind_t g;
    pdfs_kind_t i;
    pdfs_kind_t o;
    pdfs_kind_t b;
    pdfs_kind_t r;
    g = PDFS_KIND_GPIO;
    i = PDFS_KIND_IN;
    o = PDFS_KIND_OUT;
    b = PDFS_KIND_IO;
    r = PDFS_KIND_RSV;
    case (pin)
      4'hf:    return pdfs_pick(c, g, i, r, i);
      4'he:    return pdfs_pick(c, g, i, r, o);
      4'hd:    return pdfs_pick(c, g, i, i, i);
      4'hc:    return pdfs_pick(c, g, i, i, o);
      4'hb:    return pdfs_pick(c, g, b, b, r);
      4'ha:    return pdfs_pick(c, g, b, b, r);
      4'h9:    return pdfs_pick(c, g, o, i, o);
      4'h8:    return pdfs_pick(c, g, i, r, r);
      4'h3:    return pdfs_pick(c, g, o, i, r);
      4'h2:    return pdfs_pick(c, g, o, b, r);
      4'h1:    return pdfs_pick(c, g, o, o, r);
      4'h0:    return pdfs_pick(c, g, o, b, r);
      default: return pdfs_pick(c, g, o, r, r);
    endcase
  endfunction : pdfs_pin_kind

endpackage : pdfs_pkg

`default_nettype wire

// ### testbench/pdfs_periph_model.sv
// Peripheral side model: output enables of the bidirectional port A functions
`default_nettype none

module pdfs_periph_model (
  input  wire logic        clk,
  input  wire logic        srst,
  output logic      [15:0] pa_periph_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Enable pattern
  // Changes every cycle so a stale or late sample cannot pass for a match
  always @(posedge clk) begin
    if (srst) begin
      pa_periph_oe <= 16'h0000;
    end else begin
      pa_periph_oe <= 16'($urandom);
    end
  end

endmodule : pdfs_periph_model

`default_nettype wire

// ### testbench/port_direction_function_select_tb.sv
// Self-checking bench for the port direction and function select block
`default_nettype none

module port_direction_function_select_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk;
  logic                    srst;
  logic             [27:0] reg_addr;
  logic             [15:0] reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic             [15:0] reg_rdata;
  logic             [15:0] port_a_dir;
  logic             [15:0] port_b_dir;
  logic             [15:0] pa_periph_oe;
  logic             [15:0] pa_pin_oe;
  logic             [15:0] pa_gpio_sel;
  pdfs_pkg::pdfs_func_en_t pa_func_en;
  int                      miscompares = 0;
  int                      cmp_count = 0;
  logic             [27:0] adr [4] = '{28'h5ffffc4, 28'h5ffffc6, 28'h5ffffc8, 28'h5ffffca};
  logic             [15:0] rst [4] = '{16'h0000, 16'h0000, 16'h3302, 16'hff95};
  logic             [15:0] mir [4];

  pdfs_port_ctrl #(.PINS(16)) uut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_dir(port_a_dir), .port_b_dir(port_b_dir), .pa_periph_oe(pa_periph_oe),
    .pa_pin_oe(pa_pin_oe), .pa_gpio_sel(pa_gpio_sel), .pa_func_en(pa_func_en));

  pdfs_periph_model periph (.clk(clk), .srst(srst), .pa_periph_oe(pa_periph_oe));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [27:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  function automatic logic [15:0] expv(input int i, input logic [15:0] w);
    case (i)
      2:       return (w & 16'hfffd) | 16'h0002;
      3:       return (w & 16'h55ff) | 16'haa00;
      default: return w;
    endcase
  endfunction : expv

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #20000;
    miscompares++;
    end_sim();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] w;
    int          i;
    srst = 1'b1;
    reg_addr = 28'h0000000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(75));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("ack1", pa_func_en.dma_ack1_out, 1);
    chk("gpio15", pa_gpio_sel[15], 1);
    chk("oe_rst", pa_pin_oe, 16'h50f7);
    chk("gpio_rst", pa_gpio_sel, 16'haf00);
    for (i = 0; i < 4; i++) begin
      rd(adr[i], d);
      chk("reset", d, rst[i]);
      mir[i] = rst[i];
    end
    rd(28'h5ffffcc, d);
    chk("unmapped", d, 0);
    for (int n = 0; n < 40; n++) begin
      i = $urandom_range(3);
      w = 16'($urandom);
      wr(adr[i], w);
      mir[i] = expv(i, w);
      rd(adr[i], d);
      chk("readback", d, mir[i]);
      chk("dirs", {port_b_dir, port_a_dir}, {mir[1], mir[0]});
    end
    // Every code of pin 15 and pin 3, direction set to output
    for (int c = 0; c < 4; c++) begin
      wr(adr[0], 16'h8008);
      wr(adr[2], {c[1:0], 14'h0002});
      wr(adr[3], {8'haa, c[1:0], 6'h00});
      repeat (2) @(posedge clk);
      #1;
      chk("gpio15", pa_gpio_sel[15], c == 0);
      chk("oe15", pa_pin_oe[15], c == 0);
      chk("int3", pa_func_en.ext_int3_in, c == 1);
      chk("dma_req1_in", pa_func_en.dma_req1_in, c == 3);
      chk("oe3", pa_pin_oe[3], c < 2);
      chk("cs7", pa_func_en.chip_sel7_out, c == 1);
      chk("wait", pa_func_en.wait_state_in, c == 2);
      chk("grant", pa_func_en.bus_grant_out, 0);
    end
    // Mid-run reset must restore every register after arbitrary writes
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd(adr[i], d);
      chk("rerst", d, rst[i]);
    end
    end_sim();
  end

endmodule : port_direction_function_select_tb

`default_nettype wire

// ### verilog/pdfs_pin_drive.sv
// Per-pin output enable and general I/O select for one port A pin
`default_nettype none

module pdfs_pin_drive (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               dir,
  input  wire pdfs_pkg::pdfs_kind_t kind,
  input  wire logic               periph_oe,
  output logic                    pin_oe,
  output logic                    gpio_sel
);

  // ==========================================================================
  // Drive resolution
  logic next_pin_oe;

  always_comb begin
    case (kind)
      pdfs_pkg::PDFS_KIND_GPIO: next_pin_oe = dir;
      pdfs_pkg::PDFS_KIND_OUT:  next_pin_oe = 1'b1;
      pdfs_pkg::PDFS_KIND_IO:   next_pin_oe = periph_oe;
      // Inputs and reserved codes leave the pin floating, never contending
      default:                  next_pin_oe = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= next_pin_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gpio_sel <= 1'b0;
    end else begin
      gpio_sel <= (kind == pdfs_pkg::PDFS_KIND_GPIO);
    end
  end

endmodule : pdfs_pin_drive

`default_nettype wire

// ### verilog/pdfs_port_ctrl.sv
// Port A/B direction registers and port A pin function select
//
// Strobed register access was left to the implementer.
`default_nettype none

module pdfs_port_ctrl #(
  parameter int PINS = pdfs_pkg::PINS
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [pdfs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pdfs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pdfs_pkg::DATA_W-1:0] reg_rdata,
  output logic      [PINS-1:0]             port_a_dir,
  output logic      [PINS-1:0]             port_b_dir,
  input  wire logic [PINS-1:0]             pa_periph_oe,
  output logic      [PINS-1:0]             pa_pin_oe,
  output logic      [PINS-1:0]             pa_gpio_sel,
  output pdfs_pkg::pdfs_func_en_t          pa_func_en
);

  // ==========================================================================
  // Register file
  logic [pdfs_pkg::DATA_W-1:0] port_a_upper_function;
  logic [pdfs_pkg::DATA_W-1:0] port_a_lower_function;

  logic wr_pa_dir;
  logic wr_pb_dir;
  logic wr_upper;
  logic wr_lower;

  assign wr_pa_dir = reg_wr && (reg_addr == pdfs_pkg::OFS_PA_DIR);
  assign wr_pb_dir = reg_wr && (reg_addr == pdfs_pkg::OFS_PB_DIR);
  assign wr_upper  = reg_wr && (reg_addr == pdfs_pkg::OFS_PA_UPPER);
  assign wr_lower  = reg_wr && (reg_addr == pdfs_pkg::OFS_PA_LOWER);

  always_ff @(posedge clk) begin
    if (srst) begin
      port_a_dir <= pdfs_pkg::RST_DIR;
    end else if (wr_pa_dir) begin
      port_a_dir <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_b_dir <= pdfs_pkg::RST_DIR;
    end else if (wr_pb_dir) begin
      port_b_dir <= reg_wdata;
    end
  end

  // Fixed bits are forced on write, so they can never be lost
  always_ff @(posedge clk) begin
    if (srst) begin
      port_a_upper_function <= pdfs_pkg::RST_PA_UPPER;
    end else if (wr_upper) begin
      port_a_upper_function <= (reg_wdata & pdfs_pkg::WMASK_UPPER)
                               | pdfs_pkg::FIXED_UPPER;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_a_lower_function <= pdfs_pkg::RST_PA_LOWER;
    end else if (wr_lower) begin
      port_a_lower_function <= (reg_wdata & pdfs_pkg::WMASK_LOWER)
                               | pdfs_pkg::FIXED_LOWER;
    end
  end

  // ==========================================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= pdfs_pkg::RDATA_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        pdfs_pkg::OFS_PA_DIR:   reg_rdata <= port_a_dir;
        pdfs_pkg::OFS_PB_DIR:   reg_rdata <= port_b_dir;
        pdfs_pkg::OFS_PA_UPPER: reg_rdata <= port_a_upper_function;
        pdfs_pkg::OFS_PA_LOWER: reg_rdata <= port_a_lower_function;
        default:                reg_rdata <= pdfs_pkg::RDATA_UNMAPPED;
      endcase
    end else begin
      reg_rdata <= pdfs_pkg::RDATA_UNMAPPED;
    end
  end

  // ==========================================================================
  // Per-pin function code and drive
  logic [1:0] pin_code [PINS];

  for (genvar p = 0; p < PINS; p++) begin : g_pin
    if (p >= pdfs_pkg::PIN_UPPER_2B) begin : g_up2
      assign pin_code[p] =
        port_a_upper_function[2*(p-pdfs_pkg::PIN_SINGLE_HI) +: 2];
    end else if (p == pdfs_pkg::PIN_SINGLE_HI) begin : g_up1
      assign pin_code[p] = {1'b0, port_a_upper_function[0]};
    end else if (p >= pdfs_pkg::PIN_SINGLE_LO) begin : g_lo1
      assign pin_code[p] = {1'b0, port_a_lower_function[2*p]};
    end else begin : g_lo2
      assign pin_code[p] = port_a_lower_function[2*p +: 2];
    end

    pdfs_pin_drive u_drive (
      .clk       (clk),
      .srst      (srst),
      .dir       (port_a_dir[p]),
      .kind      (pdfs_pkg::pdfs_pin_kind(4'(p), pin_code[p])),
      .periph_oe (pa_periph_oe[p]),
      .pin_oe    (pa_pin_oe[p]),
      .gpio_sel  (pa_gpio_sel[p])
    );
  end

  // ==========================================================================
  // Peripheral function enables
  pdfs_pkg::pdfs_func_en_t next_func_en;

  always_comb begin
    next_func_en                      = '0;
    next_func_en.ext_int3_in          = pin_code[15] == pdfs_pkg::CODE_F1;
    next_func_en.dma_req1_in          = pin_code[15] == pdfs_pkg::CODE_F3;
    next_func_en.ext_int2_in          = pin_code[14] == pdfs_pkg::CODE_F1;
    next_func_en.dma_ack1_out         = pin_code[14] == pdfs_pkg::CODE_F3;
    next_func_en.ext_int1_in          = pin_code[13] == pdfs_pkg::CODE_F1;
    next_func_en.timer_ext_clk_b      = pin_code[13] == pdfs_pkg::CODE_F2;
    next_func_en.dma_req1_alt_in      = pin_code[13] == pdfs_pkg::CODE_F3;
    next_func_en.ext_int0_in          = pin_code[12] == pdfs_pkg::CODE_F1;
    next_func_en.timer_ext_clk_a      = pin_code[12] == pdfs_pkg::CODE_F2;
    next_func_en.dma_ack0_out         = pin_code[12] == pdfs_pkg::CODE_F3;
    next_func_en.hi_parity_io         = pin_code[11] == pdfs_pkg::CODE_F1;
    next_func_en.timer1_capcmp_b      = pin_code[11] == pdfs_pkg::CODE_F2;
    next_func_en.lo_parity_io         = pin_code[10] == pdfs_pkg::CODE_F1;
    next_func_en.timer1_capcmp_a      = pin_code[10] == pdfs_pkg::CODE_F2;
    next_func_en.address_hold_out     = pin_code[9] == pdfs_pkg::CODE_F1;
    next_func_en.converter_trigger_in = pin_code[9] == pdfs_pkg::CODE_F2;
    next_func_en.int_request_out      = pin_code[9] == pdfs_pkg::CODE_F3;
    next_func_en.bus_request_in       = pin_code[8] == pdfs_pkg::CODE_F1;
    next_func_en.bus_grant_out        = pin_code[7] == pdfs_pkg::CODE_F1;
    next_func_en.read_strobe_out      = pin_code[6] == pdfs_pkg::CODE_F1;
    next_func_en.high_store_strobe    = pin_code[5] == pdfs_pkg::CODE_F1;
    next_func_en.low_store_strobe     = pin_code[4] == pdfs_pkg::CODE_F1;
    next_func_en.chip_sel7_out        = pin_code[3] == pdfs_pkg::CODE_F1;
    next_func_en.wait_state_in        = pin_code[3] == pdfs_pkg::CODE_F2;
    next_func_en.chip_sel6_out        = pin_code[2] == pdfs_pkg::CODE_F1;
    next_func_en.timer0_capcmp_b      = pin_code[2] == pdfs_pkg::CODE_F2;
    next_func_en.chip_sel5_out        = pin_code[1] == pdfs_pkg::CODE_F1;
    next_func_en.row_addr_strobe_out  = pin_code[1] == pdfs_pkg::CODE_F2;
    next_func_en.chip_sel4_out        = pin_code[0] == pdfs_pkg::CODE_F1;
    next_func_en.timer0_capcmp_a      = pin_code[0] == pdfs_pkg::CODE_F2;
  end

  // Registered so peripherals never see decode glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      pa_func_en <= '0;
    end else begin
      pa_func_en <= next_func_en;
    end
  end

  // ==========================================================================
  // Assertions
  // Held one edge past reset: the release lands by NBA on the edge where checks start
  logic srst_q;

  always_ff @(posedge clk) begin
    srst_q <= srst;
  end

  property p_pa_dir_write;
    @(posedge clk) disable iff (srst || srst_q)
      wr_pa_dir |=> (port_a_dir == $past(reg_wdata)) ##1 (!pa_gpio_sel[15] ||
                    (pa_pin_oe[15] == $past(port_a_dir[15])));
  endproperty
  a_pa_dir_write: assert property (p_pa_dir_write)
    else $error("port A direction did not take the written value");

  property p_pa_gpio_oe;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[15] == pdfs_pkg::CODE_GPIO) |=> (pa_pin_oe[15] == $past(port_a_dir[15]));
  endproperty
  a_pa_gpio_oe: assert property (p_pa_gpio_oe)
    else $error("gpio pin drive does not follow its direction bit");

  property p_pb_dir_write;
    @(posedge clk) disable iff (srst || srst_q)
      wr_pb_dir |=> port_b_dir == $past(reg_wdata);
  endproperty
  a_pb_dir_write: assert property (p_pb_dir_write)
    else $error("port B direction did not take the written value");

  property p_reset_values;
    @(posedge clk) disable iff (srst || srst_q)
      $fell(srst) |-> (port_a_dir == pdfs_pkg::RST_DIR) && (port_b_dir == pdfs_pkg::RST_DIR)
                      && (port_a_upper_function == pdfs_pkg::RST_PA_UPPER)
                      && (port_a_lower_function == pdfs_pkg::RST_PA_LOWER);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("registers not at reset values after reset");

  property p_pin15_dma;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[15] == pdfs_pkg::CODE_F3) |=> pa_func_en.dma_req1_in && !pa_func_en.ext_int3_in;
  endproperty
  a_pin15_dma: assert property (p_pin15_dma)
    else $error("pin 15 code 11 did not select DMA request 1");

  property p_pin14_int;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[14] == pdfs_pkg::CODE_F1) |=> pa_func_en.ext_int2_in && !pa_func_en.dma_ack1_out;
  endproperty
  a_pin14_int: assert property (p_pin14_int)
    else $error("pin 14 code 01 did not select interrupt 2");

  property p_pin13_tclk;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[13] == pdfs_pkg::CODE_F2) |=> pa_func_en.timer_ext_clk_b;
  endproperty
  a_pin13_tclk: assert property (p_pin13_tclk)
    else $error("pin 13 code 10 did not select timer clock B");

  property p_pin12_ack_out;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[12] == pdfs_pkg::CODE_F3) |=> pa_func_en.dma_ack0_out && pa_pin_oe[12];
  endproperty
  a_pin12_ack_out: assert property (p_pin12_ack_out)
    else $error("pin 12 code 11 did not drive DMA ack 0");

  property p_pin11_cap;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[11] == pdfs_pkg::CODE_F2) |=> pa_func_en.timer1_capcmp_b;
  endproperty
  a_pin11_cap: assert property (p_pin11_cap)
    else $error("pin 11 code 10 did not select timer1 B");

  property p_pin10_parity;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[10] == pdfs_pkg::CODE_F1) |=> pa_func_en.lo_parity_io
                                              && (pa_pin_oe[10] == $past(pa_periph_oe[10]));
  endproperty
  a_pin10_parity: assert property (p_pin10_parity)
    else $error("pin 10 parity drive does not follow the peripheral");

  property p_pin9_trig_in;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[9] == pdfs_pkg::CODE_F2) |=> pa_func_en.converter_trigger_in && !pa_pin_oe[9];
  endproperty
  a_pin9_trig_in: assert property (p_pin9_trig_in)
    else $error("pin 9 trigger input not selected or pin driven");

  property p_upper_fixed;
    @(posedge clk) disable iff (srst || srst_q)
      wr_upper |=> port_a_upper_function[1] &&
                   (port_a_upper_function[0] == $past(reg_wdata[0]));
  endproperty
  a_upper_fixed: assert property (p_upper_fixed)
    else $error("upper function fixed bit lost or pin 8 bit not written");

  property p_lower_fixed;
    @(posedge clk) disable iff (srst || srst_q)
      wr_lower |=> ((port_a_lower_function & pdfs_pkg::FIXED_LOWER) == pdfs_pkg::FIXED_LOWER);
  endproperty
  a_lower_fixed: assert property (p_lower_fixed)
    else $error("lower function unassigned bits not held at one");

  property p_pin7_grant;
    @(posedge clk) disable iff (srst || srst_q)
      port_a_lower_function[14] |=> pa_func_en.bus_grant_out && pa_pin_oe[7];
  endproperty
  a_pin7_grant: assert property (p_pin7_grant)
    else $error("pin 7 select did not drive bus grant");

  property p_pin3_wait;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[3] == pdfs_pkg::CODE_F2) |=> pa_func_en.wait_state_in && !pa_pin_oe[3];
  endproperty
  a_pin3_wait: assert property (p_pin3_wait)
    else $error("pin 3 code 10 did not select wait input");

  property p_pin2_cs;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[2] == pdfs_pkg::CODE_F1) |=> pa_func_en.chip_sel6_out && pa_pin_oe[2];
  endproperty
  a_pin2_cs: assert property (p_pin2_cs)
    else $error("pin 2 code 01 did not drive chip select 6");

  property p_pin1_ras;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[1] == pdfs_pkg::CODE_F2) |=> pa_func_en.row_addr_strobe_out && pa_pin_oe[1];
  endproperty
  a_pin1_ras: assert property (p_pin1_ras)
    else $error("pin 1 code 10 did not drive row strobe");

  property p_reserved_undriven;
    @(posedge clk) disable iff (srst || srst_q)
      (pin_code[0] == pdfs_pkg::CODE_F3) |=> !pa_pin_oe[0] && !pa_gpio_sel[0]
                                             && !pa_func_en.chip_sel4_out;
  endproperty
  a_reserved_undriven: assert property (p_reserved_undriven)
    else $error("reserved code left pin 0 driven or selected");

  property p_read_back;
    @(posedge clk) disable iff (srst || srst_q)
      (reg_rd && (reg_addr == pdfs_pkg::OFS_PA_UPPER)) |=>
        reg_rdata == $past(port_a_upper_function);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("upper function read did not return the register");

endmodule : pdfs_port_ctrl

`default_nettype wire
